// ### logic/txsf_status.v
/*
 Transmit status flag logic of the media access unit. Derives per-packet
 status bits from carrier sense, collisions, deferral, FIFO underrun,
 descriptor byte counts and self-monitoring, holds them in the transmit
 control/status register and hands a status word to the descriptor writer.
 Assumes the transmit sequencer supplies single-cycle event pulses on clk
 and that carrier sense and receive activity arrive asynchronously on pins.
 Registers are reached over an Avalon-MM slave with waitrequest.
*/
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "txsf_defines.vh"

module txsf_status #(
  parameter SLOT_CYCLES = `TXSF_SLOT_CYCLES  // Late-collision window in cycles
) (
  input  wire        clk,                // System clock, 25 MHz
  input  wire        srst,               // Synchronous reset, active high
  // Avalon-MM slave
  input  wire [3:0]  avs_address,        // Byte address
  input  wire        avs_read,           // Read request
  input  wire        avs_write,          // Write request
  input  wire [31:0] avs_writedata,      // Write data
  input  wire [3:0]  avs_byteenable,     // Byte lanes
  output reg  [31:0] avs_readdata,       // Read data
  output reg         avs_waitrequest,    // Stall until answer ready
  // Medium pins
  input  wire        carrier_sense,      // Carrier sense pin, asynchronous
  input  wire        rx_activity,        // Receive pair activity, asynchronous
  // Transmit sequencer events
  input  wire        tx_start,           // New packet begins, pulse
  input  wire        preamble_start,     // First preamble bit, pulse
  input  wire        sfd_start,          // Frame delimiter begins, pulse
  input  wire        last_byte,          // Last byte leaves, pulse
  input  wire        collision,          // Collision seen, pulse
  input  wire        deferring,          // Waiting for medium, level
  input  wire        fifo_empty,         // Transmit FIFO empty, level
  input  wire        bus_granted,        // System bus won for refill, level
  input  wire        fifo_needed,        // Frame still needs FIFO data, level
  input  wire [15:0] pkt_size,           // Descriptor total length
  input  wire [15:0] frag_sum,           // Sum of fragment lengths
  input  wire        frag_sum_valid,     // Fragment sum complete, pulse
  input  wire        mon_align_err,      // Self-check CRC error from alignment
  input  wire        mon_addr_miss,      // Self-check source address miss
  input  wire        mon_done,           // Self-check of frame finished, pulse
  input  wire        mac_loopback,       // MAC loopback mode
  input  wire        other_loopback,     // Encoder or transceiver loopback
  input  wire        status_written,     // Descriptor status stored, pulse
  // Outputs
  output reg         tx_abort_ff,        // Abort the transmission, pulse
  output reg         fcs_append_ff,      // Append 4-byte check sequence
  output reg         crc_check_en_ff,    // Self-check checksum enable
  output reg         status_valid_ff,    // Status word ready, pulse
  output reg  [15:0] status_word_ff      // Status bits and collision count
);

  // ==========================================================
  // Declarations
  localparam ST_IDLE = 3'b001;
  localparam ST_TX   = 3'b010;
  localparam ST_WB   = 3'b100;

  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [15:0] tcs_ff;         // Transmit control/status register
  reg [15:0] nxt_tcs;
  reg [4:0]  coll_cnt_ff;
  reg [4:0]  nxt_coll_cnt;
  reg        crs_window_ff;  // Carrier being watched
  reg        first_try_ff;   // Still in the first attempt
  reg        crs_seen_ff;    // Carrier appeared in the window
  reg        nxt_abort;
  reg        timer_start;
  reg        timer_stop;
  wire       crs_sync;
  wire       rxa_sync;
  wire       late_window;
  wire       bus_hit;
  wire       wr_tcs;
  wire       any_loop;

  // ==========================================================
  // Pin synchronisers
  txsf_sync u_crs_sync (
    .clk     (clk),
    .srst    (srst),
    .din     (carrier_sense),
    .dout_ff (crs_sync)
  );

  txsf_sync u_rxa_sync (
    .clk     (clk),
    .srst    (srst),
    .din     (rx_activity),
    .dout_ff (rxa_sync)
  );

  // ==========================================================
  // Late-collision window timer
  txsf_late_timer #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_late_timer (
    .clk        (clk),
    .srst       (srst),
    .start      (timer_start),
    .stop       (timer_stop),
    .expired_ff (late_window)
  );

  // Reference point chosen by the window-start setting
  always @* begin
    timer_stop  = (state_ff != ST_TX);
    timer_start = 1'b0;
    if (state_ff == ST_TX) begin
      if (tcs_ff[`TXSF_BIT_WIN_START]) begin
        timer_start = preamble_start;
      end else begin
        timer_start = sfd_start;
      end
    end
  end

  assign any_loop = mac_loopback | other_loopback;

  // ==========================================================
  // Bus decode; only the control field bits are writable
  // A write lands on the edge that completes the transfer, not while stalled
  assign bus_hit = avs_read | avs_write;
  assign wr_tcs  = avs_write && !avs_waitrequest &&
                   (avs_address == `TXSF_OFS_TCS) && avs_byteenable[1];

  // ==========================================================
  // Sequencer and flag next-state logic
  always @* begin
    nxt_state    = state_ff;
    nxt_tcs      = tcs_ff;
    nxt_coll_cnt = coll_cnt_ff;
    nxt_abort    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (tx_start) begin
          // Per-packet bits restart; no-carrier armed until carrier seen
          nxt_tcs[`TXSF_BIT_EXCESS_DEFER]    = 1'b0;
          nxt_tcs[`TXSF_BIT_CARRIER_LOST]    = 1'b0;
          nxt_tcs[`TXSF_BIT_EXCESS_COLL]     = 1'b0;
          nxt_tcs[`TXSF_BIT_LEN_MISMATCH]    = 1'b0;
          nxt_tcs[`TXSF_BIT_NO_CARRIER]      = 1'b1;
          nxt_tcs[`TXSF_BIT_MON_BAD]         = 1'b0;
          nxt_tcs[`TXSF_BIT_UNDERRUN]        = 1'b0;
          nxt_tcs[`TXSF_BIT_TX_OK]           = 1'b0;
          nxt_coll_cnt                       = 5'h00;
          nxt_state                          = ST_TX;
        end
      end
      ST_TX: begin
        if (preamble_start) begin
          nxt_tcs[`TXSF_BIT_NO_CARRIER] = 1'b1;
        end
        if (crs_window_ff && crs_sync && !mac_loopback) begin
          nxt_tcs[`TXSF_BIT_NO_CARRIER] = 1'b0;
        end
        if (mac_loopback && rxa_sync) begin
          nxt_tcs[`TXSF_BIT_NO_CARRIER] = 1'b0;
        end
        // Carrier drop seen only after it had been present
        if (crs_window_ff && crs_seen_ff && !crs_sync) begin
          nxt_tcs[`TXSF_BIT_CARRIER_LOST] = 1'b1;
        end
        if (deferring && first_try_ff) begin
          nxt_tcs[`TXSF_BIT_DEFERRED] = 1'b1;
        end
        if (collision) begin
          nxt_coll_cnt = coll_cnt_ff + 5'h01;
          if (late_window) begin
            nxt_tcs[`TXSF_BIT_LATE_COLL] = 1'b1;
          end
          if (nxt_coll_cnt == `TXSF_MAX_COLL) begin
            nxt_tcs[`TXSF_BIT_EXCESS_COLL]  = 1'b1;
            nxt_tcs[`TXSF_BIT_LEN_MISMATCH] = 1'b1;
            nxt_abort                       = 1'b1;
          end
        end
        if (fifo_needed && fifo_empty && !bus_granted) begin
          nxt_tcs[`TXSF_BIT_UNDERRUN] = 1'b1;
          nxt_abort                   = 1'b1;
        end
        if (frag_sum_valid && (frag_sum != pkt_size)) begin
          nxt_tcs[`TXSF_BIT_LEN_MISMATCH] = 1'b1;
          nxt_abort                       = 1'b1;
        end
        if (mon_done && (mon_align_err || mon_addr_miss) &&
            !tcs_ff[`TXSF_BIT_CRC_INH] && !any_loop) begin
          nxt_tcs[`TXSF_BIT_MON_BAD] = 1'b1;
        end
        if (last_byte || nxt_abort) begin
          // No carrier at all sets both flags; MAC loopback always loses it
          if (!crs_seen_ff || mac_loopback) begin
            nxt_tcs[`TXSF_BIT_CARRIER_LOST] = 1'b1;
          end
          nxt_tcs[`TXSF_BIT_TX_OK] = !(nxt_tcs[`TXSF_BIT_EXCESS_COLL] |
                                       nxt_tcs[`TXSF_BIT_EXCESS_DEFER] |
                                       nxt_tcs[`TXSF_BIT_UNDERRUN]);
          nxt_state = ST_WB;
        end
      end
      ST_WB: begin
        if (status_written) begin
          nxt_tcs[`TXSF_BIT_DEFERRED]  = 1'b0;
          nxt_tcs[`TXSF_BIT_LATE_COLL] = 1'b0;
          nxt_state                    = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Monitored-bad can never show while inhibited or looped back
    if (tcs_ff[`TXSF_BIT_CRC_INH] || any_loop) begin
      nxt_tcs[`TXSF_BIT_MON_BAD] = 1'b0;
    end
    // Software steers only the mode bits 15..12
    if (wr_tcs) begin
      nxt_tcs[15:12] = avs_writedata[15:12];
    end
    nxt_tcs[`TXSF_BIT_ZERO_HI] = 1'b0;
    nxt_tcs[`TXSF_BIT_ZERO_LO] = 1'b0;
  end

  // ==========================================================
  // State, flags and outputs; srst is the hardware reset
  always @(posedge clk) begin
    if (srst) begin
      state_ff        <= ST_IDLE;
      tcs_ff          <= `TXSF_TCS_RESET;
      coll_cnt_ff     <= 5'h00;
      crs_window_ff   <= 1'b0;
      first_try_ff    <= 1'b0;
      crs_seen_ff     <= 1'b0;
      tx_abort_ff     <= 1'b0;
      fcs_append_ff   <= 1'b1;
      crc_check_en_ff <= 1'b0;
      status_valid_ff <= 1'b0;
      status_word_ff  <= 16'h0000;
    end else begin
      state_ff    <= nxt_state;
      tcs_ff      <= nxt_tcs;
      coll_cnt_ff <= nxt_coll_cnt;
      tx_abort_ff <= nxt_abort;
      // Carrier window from delimiter through last byte
      if (state_ff == ST_TX && sfd_start) begin
        crs_window_ff <= 1'b1;
      end else if (last_byte || state_ff != ST_TX) begin
        crs_window_ff <= 1'b0;
      end
      if (tx_start && state_ff == ST_IDLE) begin
        crs_seen_ff  <= 1'b0;
        first_try_ff <= 1'b1;
      end else begin
        if (crs_window_ff && crs_sync) begin
          crs_seen_ff <= 1'b1;
        end
        if (collision) begin
          first_try_ff <= 1'b0;
        end
      end
      fcs_append_ff   <= !tcs_ff[`TXSF_BIT_CRC_INH];
      crc_check_en_ff <= (state_ff == ST_TX);
      // Status word: count in 15..11, flags in 10..0
      status_valid_ff <= (state_ff == ST_TX) && (nxt_state == ST_WB);
      if (state_ff == ST_TX && nxt_state == ST_WB) begin
        status_word_ff <= {nxt_coll_cnt, nxt_tcs[10:0]};
      end
    end
  end

  // ==========================================================
  // Avalon slave: one wait cycle, answer on the second edge
  always @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !(bus_hit && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `TXSF_OFS_TCS:         avs_readdata <= {16'h0000, tcs_ff};
          `TXSF_OFS_TX_CTRL:     avs_readdata <= {24'h000000, 3'h0, coll_cnt_ff};
          `TXSF_OFS_STATUS_WORD: avs_readdata <= {16'h0000, status_word_ff};
          default:               avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ### common/txsf_defines.vh
/*
 Constants for the transmit status flag logic: register offsets, field
 positions, reset values and timing counts. Assumes a 25 MHz system clock.
*/
`ifndef TXSF_DEFINES_VH
`define TXSF_DEFINES_VH

// ==========================================================
// Register byte offsets on the Avalon-MM slave
`define TXSF_OFS_TCS          4'h0
`define TXSF_OFS_TX_CTRL      4'h4
`define TXSF_OFS_STATUS_WORD  4'h8

// ==========================================================
// Transmit control/status field positions
`define TXSF_BIT_WIN_START    14
`define TXSF_BIT_CRC_INH      13
`define TXSF_BIT_DEFERRED     9
`define TXSF_BIT_NO_CARRIER   8
`define TXSF_BIT_CARRIER_LOST 7
`define TXSF_BIT_EXCESS_COLL  6
`define TXSF_BIT_LATE_COLL    5
`define TXSF_BIT_MON_BAD      3
`define TXSF_BIT_UNDERRUN     2
`define TXSF_BIT_LEN_MISMATCH 1
`define TXSF_BIT_TX_OK        0
`define TXSF_BIT_EXCESS_DEFER 10
`define TXSF_BIT_ZERO_HI      11
`define TXSF_BIT_ZERO_LO      4

// Hardware reset value: no-carrier and tx-ok set, mismatch clear
`define TXSF_TCS_RESET        16'h0101

// ==========================================================
// Collision and timing figures
`define TXSF_MAX_COLL         5'h10
`define TXSF_SLOT_TIME_NS     51200
`define TXSF_CLK_PERIOD_NS    40
`define TXSF_SLOT_CYCLES      (`TXSF_SLOT_TIME_NS / `TXSF_CLK_PERIOD_NS)

`endif

// ### logic/txsf_sync.v
/*
 Three-stage synchroniser with agreement filter for a pin input.
 Assumes the input is asynchronous to clk; output follows once stages
 two and three agree.
*/
`timescale 1ns/100ps

module txsf_sync (
  input  wire clk,     // System clock
  input  wire srst,    // Synchronous reset, active high
  input  wire din,     // Asynchronous pin level
  output reg  dout_ff  // Filtered synchronous level
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // ==========================================================
  // Stage chain; only s2 reads s1 to keep metastability contained
  always @(posedge clk) begin
    if (srst) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout_ff <= s3_ff;
      end
    end
  end

endmodule

// ### logic/txsf_late_timer.v
/*
 Late-collision window timer. Counts one slot time from its start pulse.
 Assumes start is a synchronous pulse and stop a synchronous level on clk.
*/
`timescale 1ns/100ps
`include "txsf_defines.vh"

module txsf_late_timer #(
  parameter SLOT_CYCLES = `TXSF_SLOT_CYCLES  // Slot time in clock cycles
) (
  input  wire clk,          // System clock
  input  wire srst,         // Synchronous reset, active high
  input  wire start,        // Begin timing the window
  input  wire stop,         // Frame ended, stop timing
  output reg  expired_ff    // Slot time elapsed since start
);

  reg [11:0] cnt_ff;
  reg        run_ff;

  // ==========================================================
  // Counter stops at the slot limit so expired stays until stop or a new start
  always @(posedge clk) begin
    if (srst || stop) begin
      cnt_ff     <= 12'h000;
      run_ff     <= 1'b0;
      expired_ff <= 1'b0;
    end else if (start) begin
      cnt_ff     <= 12'h000;
      run_ff     <= 1'b1;
      expired_ff <= 1'b0;
    end else if (run_ff) begin
      if (cnt_ff == SLOT_CYCLES[11:0] - 12'h001) begin
        expired_ff <= 1'b1;
        run_ff     <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff + 12'h001;
      end
    end
  end

endmodule

// ### testbench/txsf_status_asserts.sv
/*
 Checker for the transmit status flag logic, bound to the ports of txsf_status.
 Assumes event inputs are single-cycle pulses on clk and reset is srst.
*/
`timescale 1ns/100ps

module txsf_status_asserts (
  input wire        clk,             // System clock
  input wire        srst,            // Sync reset
  input wire        avs_read,        // Read request
  input wire        avs_write,       // Write request
  input wire        avs_waitrequest, // Slave stall
  input wire        tx_start,        // Frame start
  input wire        sfd_start,       // Delimiter start
  input wire        last_byte,       // Last byte out
  input wire        collision,       // Collision pulse
  input wire        fifo_empty,      // FIFO empty
  input wire        fifo_needed,     // FIFO data needed
  input wire        bus_granted,     // Bus won
  input wire [15:0] pkt_size,        // Total length
  input wire [15:0] frag_sum,        // Fragment sum
  input wire        frag_sum_valid,  // Sum ready
  input wire        mac_loopback,    // MAC loopback
  input wire        other_loopback,  // Other loopback
  input wire        fcs_append_ff,   // Checksum appended
  input wire        crc_check_en_ff, // Self-check on
  input wire        tx_abort_ff,     // Abort pulse
  input wire        status_valid_ff, // Status ready
  input wire [15:0] status_word_ff   // Status word
);
  // ==========
  // Frame tracking
  reg       in_frame_ff;
  reg [4:0] coll_cnt_ff;

  // Open from start to status; count restarts with each frame
  always @(posedge clk) begin
    if (srst || status_valid_ff)
      in_frame_ff <= 1'b0;
    else if (tx_start)
      in_frame_ff <= 1'b1;
    if (srst || tx_start)
      coll_cnt_ff <= 5'h00;
    else if (collision)
      coll_cnt_ff <= coll_cnt_ff + 5'h01;
  end

  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer off");
  a_status_at_end: assert property (in_frame_ff && last_byte |=> status_valid_ff)
    else $error("no status after last byte");
  a_word_held: assert property ($changed(status_word_ff) |-> status_valid_ff)
    else $error("status word moved");
  a_underrun_abort: assert property (in_frame_ff && $rose(fifo_empty && fifo_needed
    && !bus_granted) |-> ##[1:3] tx_abort_ff) else $error("underrun not aborted");
  a_length_abort: assert property (in_frame_ff && frag_sum_valid
    && pkt_size != frag_sum |-> ##[1:3] tx_abort_ff) else $error("mismatch not aborted");
  a_excess_abort: assert property (in_frame_ff && collision && coll_cnt_ff == 5'h0f
    |-> ##[1:3] tx_abort_ff) else $error("16th collision not aborted");
  a_count_reported: assert property (status_valid_ff
    |-> status_word_ff[15:11] == coll_cnt_ff) else $error("collision count wrong");
  a_excess_mismatch: assert property (status_valid_ff && status_word_ff[6]
    |-> status_word_ff[1]) else $error("excess without mismatch");
  a_carrier_pair: assert property (status_valid_ff && status_word_ff[8]
    |-> status_word_ff[7]) else $error("no-carrier without lost");
  a_loop_lost: assert property (status_valid_ff && mac_loopback
    |-> status_word_ff[7]) else $error("loopback lost clear");
  a_bad_masked: assert property (status_valid_ff && (mac_loopback || other_loopback
    || !fcs_append_ff) |-> !status_word_ff[3]) else $error("monitored-bad not masked");
  a_check_on: assert property (sfd_start |-> ##[1:2] crc_check_en_ff)
    else $error("self-check off in frame");
endmodule

bind txsf_status txsf_status_asserts i_chk (.*);

// ### testbench/txsf_medium_model.sv
/*
 Medium model: carrier sense as the transceiver reports it during a frame.
 Assumes tx_on spans preamble to status; carrier idles low between frames.
*/
`timescale 1ns/100ps

module txsf_medium_model (
  input  wire       clk,           // System clock
  input  wire       tx_on,         // Frame on the wire
  input  wire [1:0] mode,          // 0 present, 1 absent, 2 drops
  output reg        carrier_sense  // Carrier seen on the medium
);
  reg [4:0] age_ff;

  // Drop mode loses carrier well after the delimiter so it lands in the window
  initial begin
    age_ff = 5'h00;
    carrier_sense = 1'b0;
  end
  always @(posedge clk) begin
    age_ff <= tx_on ? age_ff + {4'h0, age_ff != 5'h1f} : 5'h00;
    carrier_sense <= tx_on && (mode == 2'h0 || (mode == 2'h2 && age_ff < 5'h0e));
  end
endmodule

// ### testbench/tb_txsf_status.sv
/*
 Self-checking bench for the transmit status flag logic: register access
 over Avalon-MM and one frame per status case. Assumes the medium model
 drives carrier sense; receive overrun is never raised, so monitored-bad
 has meaning here except in the CRC-inhibit and loopback frames, where it is forced clear.
*/
`timescale 1ns/100ps

module tb_txsf_status;
  // ==========
  // Signals
  logic        clk, srst, avs_read, avs_write, avs_waitrequest, carrier_sense, rx_activity;
  logic        tx_start, preamble_start, sfd_start, last_byte, collision, deferring;
  logic        fifo_empty, bus_granted, fifo_needed, frag_sum_valid, mon_done, tx_on;
  logic        mon_align_err, mon_addr_miss, mac_loopback, other_loopback, status_written;
  logic        tx_abort_ff, fcs_append_ff, crc_check_en_ff, status_valid_ff;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] pkt_size, frag_sum, status_word_ff, last_word;
  logic [1:0]  cs_mode;
  int          seen, aborts, err_total, checked;

  txsf_status #(.SLOT_CYCLES(40)) i_txsf_status (.*);
  txsf_medium_model i_medium (.clk(clk), .tx_on(tx_on), .mode(cs_mode),
                              .carrier_sense(carrier_sense));

  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Capture each status word and count abort pulses
  always @(posedge clk) begin
    if (status_valid_ff === 1'b1) begin
      last_word <= status_word_ff;
      seen <= seen + 1;
    end
    if (tx_abort_ff === 1'b1)
      aborts <= aborts + 1;
  end

  // ==========
  // Tasks
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Hold the request until waitrequest is sampled low, then release
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (n == 20) begin
      chk(16'h0000, 16'h0001);
      tally_and_finish;
    end
  endtask

  // One frame: collisions right after the delimiter, then self-check and refill
  task automatic frame(input logic [1:0] cs, input logic [4:0] nc, input logic [1:0] er,
                       input logic [1:0] mb, input logic df, input logic [7:0] ld,
                       input logic [15:0] exp);
    int s0, a0, i;
    s0 = seen;
    a0 = aborts;
    cs_mode <= cs;
    deferring <= df;
    tx_start <= 1'b1;
    @(posedge clk) tx_start <= 1'b0;
    @(posedge clk) deferring <= 1'b0;
    preamble_start <= 1'b1;
    tx_on <= 1'b1;
    @(posedge clk) preamble_start <= 1'b0;
    repeat (7) @(posedge clk);
    sfd_start <= 1'b1;
    @(posedge clk) sfd_start <= 1'b0;
    for (i = 0; i < nc; i++) begin
      @(posedge clk) collision <= 1'b1;
      @(posedge clk) collision <= 1'b0;
    end
    if (ld != 8'd0) begin
      repeat (ld - 1) @(posedge clk);
      collision <= 1'b1;
      @(posedge clk) collision <= 1'b0;
    end
    {mon_addr_miss, mon_align_err} <= mb;
    mon_done <= 1'b1;
    @(posedge clk) mon_done <= 1'b0;
    {fifo_empty, fifo_needed, bus_granted} <= (er == 2'h1) ? 3'b110 : 3'b001;
    frag_sum <= (er == 2'h2) ? 16'h003f : 16'h0040;
    frag_sum_valid <= 1'b1;
    @(posedge clk) frag_sum_valid <= 1'b0;
    repeat (3) @(posedge clk);
    {fifo_empty, fifo_needed, bus_granted} <= 3'b001;
    if (nc != 5'd16 && er == 2'h0) begin
      repeat (8) @(posedge clk);
      last_byte <= 1'b1;
      @(posedge clk) last_byte <= 1'b0;
    end
    for (i = 0; i < 50 && seen == s0; i++)
      @(posedge clk);
    if (i == 50) begin
      chk(16'h0000, 16'h0001);
      tally_and_finish;
    end
    chk(last_word, exp);
    chk({15'h0, aborts != a0}, {15'h0, nc == 5'd16 || er != 2'h0});
    tx_on <= 1'b0;
    {mon_addr_miss, mon_align_err} <= 2'b00;
    status_written <= 1'b1;
    @(posedge clk) status_written <= 1'b0;
    repeat (2) @(posedge clk);
    $display("Frame done, status %h", exp);
  endtask

  // ==========
  // Main sequence
  initial begin
    logic [31:0] q;
    {avs_read, avs_write, tx_start, preamble_start, sfd_start, last_byte, collision,
     deferring, fifo_empty, fifo_needed, frag_sum_valid, mon_align_err, mon_addr_miss,
     mon_done, mac_loopback, other_loopback, status_written, rx_activity, tx_on} = '0;
    {srst, bus_granted, avs_byteenable} = 6'h3f;
    {avs_address, avs_writedata, cs_mode} = '0;
    {pkt_size, frag_sum} = {16'h0040, 16'h0040};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q[15:0], 16'h0101);
    chk({15'h0, crc_check_en_ff}, 16'h0000);
    bus(1'b0, 4'hc, 32'h0, q);
    chk(q[15:0], 16'h0000);
    bus(1'b1, 4'h0, 32'h0000ffff, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q[15:0], 16'hf101);
    chk({15'h0, fcs_append_ff}, 16'h0000);
    bus(1'b1, 4'h0, 32'h0, q);
    repeat (2) @(posedge clk);
    chk({15'h0, fcs_append_ff}, 16'h0001);
    // Lane 1 off: the mode bits must not move
    avs_byteenable <= 4'hd;
    bus(1'b1, 4'h0, 32'h0000f000, q);
    avs_byteenable <= 4'hf;
    bus(1'b1, 4'h8, 32'h0000ffff, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q[15:0], 16'h0101);
    $display("Register access done");
    frame(2'h0, 5'd2, 2'h0, 2'h0, 1'b0, 8'd0, 16'h1001);
    frame(2'h1, 5'd0, 2'h0, 2'h0, 1'b0, 8'd0, 16'h0181);
    frame(2'h2, 5'd0, 2'h0, 2'h0, 1'b0, 8'd0, 16'h0081);
    frame(2'h0, 5'd0, 2'h0, 2'h0, 1'b1, 8'd45, 16'h0a21);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q[15:0], 16'h0001);
    bus(1'b1, 4'h0, 32'h4000, q);
    frame(2'h0, 5'd0, 2'h0, 2'h0, 1'b0, 8'd36, 16'h0821);
    bus(1'b1, 4'h0, 32'h0, q);
    frame(2'h0, 5'd0, 2'h0, 2'h0, 1'b0, 8'd36, 16'h0801);
    frame(2'h0, 5'd16, 2'h0, 2'h0, 1'b0, 8'd0, 16'h8042);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q[15:0], 16'h8042);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q[15:0], 16'h0010);
    frame(2'h0, 5'd0, 2'h1, 2'h0, 1'b0, 8'd0, 16'h0004);
    frame(2'h0, 5'd0, 2'h2, 2'h0, 1'b0, 8'd0, 16'h0003);
    frame(2'h0, 5'd0, 2'h0, 2'h1, 1'b0, 8'd0, 16'h0009);
    frame(2'h0, 5'd0, 2'h0, 2'h2, 1'b0, 8'd0, 16'h0009);
    bus(1'b1, 4'h0, 32'h2000, q);
    frame(2'h0, 5'd0, 2'h0, 2'h1, 1'b0, 8'd0, 16'h0001);
    bus(1'b1, 4'h0, 32'h0, q);
    other_loopback <= 1'b1;
    frame(2'h0, 5'd0, 2'h0, 2'h1, 1'b0, 8'd0, 16'h0001);
    other_loopback <= 1'b0;
    mac_loopback <= 1'b1;
    frame(2'h1, 5'd0, 2'h0, 2'h1, 1'b0, 8'd0, 16'h0181);
    rx_activity <= 1'b1;
    frame(2'h1, 5'd0, 2'h0, 2'h0, 1'b0, 8'd0, 16'h0081);
    tally_and_finish;
  end
endmodule
